// ### hdl/ifra_pkg.sv
package ifra_pkg;

	// Bus geometry
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int LANES = 4;

	// Register byte offsets
	localparam logic [11:0] DATA_OFS = 12'h1ac;
	localparam logic [11:0] CMD_OFS = 12'h1b0;

	// Command word field positions
	localparam int PEND_BIT = 31;
	localparam int DIR_BIT = 30;
	localparam int UP_BIT = 29;
	localparam int DOWN_BIT = 28;
	localparam int RSVD_HI = 27;
	localparam int RSVD_LO = 20;
	localparam int LANE_HI = 19;
	localparam int LANE_LO = 16;
	localparam int IDX_HI = 15;
	localparam int IDX_LO = 0;

	// Reset values
	localparam logic [31:0] DATA_RST = 32'h0000_0000;
	localparam logic [15:0] IDX_RST = 16'h0000;
	localparam logic [3:0] LANE_RST = 4'h0;
	localparam logic [7:0] RSVD_VAL = 8'h00;

	// Direction encoding
	localparam logic DIR_WRITE = 1'b0;
	localparam logic DIR_READ = 1'b1;

	// Index step
	localparam logic [15:0] IDX_STEP = 16'h0001;

	// Fabric sequencer states
	typedef enum logic {
		ST_IDLE,
		ST_WAIT
	} ifra_seq_state_t;

endpackage

// ### hdl/ifra_fab_seq.sv
`timescale 1ns/1ns
module ifra_fab_seq (
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Launch from the command engine
	input wire logic start_i,
	input wire logic dir_i,
	input wire logic [15:0] index_i,
	input wire logic [3:0] lanes_i,
	input wire logic [31:0] wdata_i,
	// Completion back to the engine
	output logic done_o,
	output logic [31:0] rdata_o,
	// Fabric register port
	output logic fab_req_o,
	output logic fab_we_o,
	output logic [15:0] fab_index_o,
	output logic [3:0] fab_lanes_o,
	output logic [31:0] fab_wdata_o,
	input wire logic fab_ack_i,
	input wire logic [31:0] fab_rdata_i
);

	ifra_pkg::ifra_seq_state_t state_reg; // Sequencer state

	// One access in flight; request held until the fabric acks
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= ifra_pkg::ST_IDLE;
			fab_req_o <= 1'b0;
			fab_we_o <= 1'b0;
			fab_index_o <= ifra_pkg::IDX_RST;
			fab_lanes_o <= ifra_pkg::LANE_RST;
			fab_wdata_o <= ifra_pkg::DATA_RST;
			done_o <= 1'b0;
			rdata_o <= ifra_pkg::DATA_RST;
		end else if (ce_i) begin
			done_o <= 1'b0;
			unique case (state_reg)
				ifra_pkg::ST_IDLE: begin
					// Starts seen while busy are impossible: the engine gates them
					if (start_i) begin // R19
						fab_req_o <= 1'b1; // R01
						fab_we_o <= (dir_i == ifra_pkg::DIR_WRITE); // R05
						fab_index_o <= index_i; // R15
						fab_lanes_o <= lanes_i; // R12 R13
						fab_wdata_o <= wdata_i;
						state_reg <= ifra_pkg::ST_WAIT;
					end
				end
				ifra_pkg::ST_WAIT: begin
					// Fabric answers with a one-cycle ack
					if (fab_ack_i) begin
						fab_req_o <= 1'b0;
						done_o <= 1'b1;
						rdata_o <= fab_rdata_i;
						state_reg <= ifra_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	// Direction bit maps onto the write strobe
	a_dir_to_we: assert property (@(posedge clk_i) disable iff (rst_i) // R05
		ce_i && start_i && state_reg == ifra_pkg::ST_IDLE |=> fab_we_o == !$past(dir_i))
		else $error("fabric write strobe does not follow direction");

	// Lane enables reach the fabric unchanged
	a_lane_pass: assert property (@(posedge clk_i) disable iff (rst_i) // R12
		ce_i && start_i && state_reg == ifra_pkg::ST_IDLE |=> fab_lanes_o == $past(lanes_i)
		&& fab_req_o)
		else $error("lane enables not passed to fabric");

endmodule

// ### hdl/ifra_cmd_engine.sv
`timescale 1ns/1ns
// Functional notes
// R01: Writing pending one starts one fabric access
// R02: Pending holds during access, hardware clears after
// R03: Read data loaded before pending clears
// R04: Software leaves registers alone while pending
// R05: Direction zero writes, direction one reads
// R06: Step-up data write launches, then index plus one
// R07: Step-up data read: index plus one, launch
// R08: Step-down data write launches, then index minus one
// R09: Step-down data read: index minus one, launch
// R10: Software clears step bit before final read
// R11: Step-up wins when both step bits set
// R12: Fabric write touches only enabled byte lanes
// R13: Lane bit n governs data byte n
// R14: Software sets all lanes for bursts
// R15: Sixteen-bit index in low command bits
// R16: Data read shows fabric or software value
// R17: Data register 32-bit, resets to zero
// R18: Reserved command bits read zero, ignore writes
// R19: Only one fabric access at a time
module ifra_cmd_engine (
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Fabric register port
	output logic fab_req_o,
	output logic fab_we_o,
	output logic [15:0] fab_index_o,
	output logic [3:0] fab_lanes_o,
	output logic [31:0] fab_wdata_o,
	input wire logic fab_ack_i,
	input wire logic [31:0] fab_rdata_i
);

	// Command fields
	logic pend_reg; // Access in flight
	logic dir_reg; // One reads, zero writes
	logic up_reg; // Step index up
	logic down_reg; // Step index down
	logic [3:0] lanes_reg; // Write lane enables
	logic [15:0] index_reg; // Fabric register index

	// Data storage
	logic [31:0] wdata_reg; // Last software-written word
	logic [31:0] rdata_reg; // Last fetched fabric word

	// Launch bookkeeping
	logic start_reg; // One-cycle launch to the sequencer
	logic op_dir_reg; // Direction of the access in flight
	logic op_up_reg; // Step up after a write completes
	logic op_down_reg; // Step down after a write completes

	// Sequencer answers
	logic seq_done;
	logic [31:0] seq_rdata;

	// Bus decode
	logic take; // New bus request this cycle
	logic hit_cmd;
	logic hit_data;
	logic cmd_wr;
	logic data_wr;
	logic data_rd;
	logic [31:0] lane_mask;
	logic [31:0] cmd_view;
	logic [31:0] cmd_merged;
	logic [31:0] data_merged;
	logic step_up; // Effective step-up after precedence
	logic step_down; // Effective step-down after precedence
	logic launch_cmd; // Command write asks for an access
	logic launch_data; // Data access asks for an access

	// Request is taken once; ack falls the cycle after it rose
	assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign hit_cmd = wb_adr_i[11:2] == ifra_pkg::CMD_OFS[11:2];
	assign hit_data = wb_adr_i[11:2] == ifra_pkg::DATA_OFS[11:2];
	assign cmd_wr = take && wb_we_i && hit_cmd;
	assign data_wr = take && wb_we_i && hit_data;
	assign data_rd = take && !wb_we_i && hit_data;

	// Byte-select mask, one byte per lane
	for (genvar b = 0; b < ifra_pkg::LANES; b++) begin : g_lane
		assign lane_mask[8*b +: 8] = {8{wb_sel_i[b]}};
	end

	// Command word as software sees it; reserved bits forced low
	assign cmd_view = {pend_reg, dir_reg, up_reg, down_reg, ifra_pkg::RSVD_VAL, // R18
		lanes_reg, index_reg}; // R15
	assign cmd_merged = (cmd_view & ~lane_mask) | (wb_dat_i & lane_mask);
	assign data_merged = (wdata_reg & ~lane_mask) | (wb_dat_i & lane_mask);

	// Step-up takes precedence over step-down
	assign step_up = up_reg; // R11
	assign step_down = down_reg && !up_reg; // R11

	// Launch requests, only while idle
	assign launch_cmd = cmd_wr && !pend_reg && wb_sel_i[3] && wb_dat_i[ifra_pkg::PEND_BIT]; // R01
	assign launch_data = (data_wr || data_rd) && !pend_reg && (step_up || step_down); // R06 R08

	// Bus answer: registered ack, one wait state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else if (ce_i) begin
			wb_ack_o <= take;
		end
	end

	// Read mux; unmapped addresses answer zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= ifra_pkg::DATA_RST;
		end else if (ce_i) begin
			if (take && !wb_we_i) begin
				if (hit_cmd) begin
					wb_dat_o <= cmd_view; // R18
				end else if (hit_data) begin
					// Fabric copy only when reading
					wb_dat_o <= (dir_reg == ifra_pkg::DIR_READ) ? rdata_reg : wdata_reg; // R16
				end else begin
					wb_dat_o <= ifra_pkg::DATA_RST;
				end
			end
		end
	end

	// Mode fields; frozen while busy so the step mode cannot change mid-burst access
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dir_reg <= ifra_pkg::DIR_WRITE;
			up_reg <= 1'b0;
			down_reg <= 1'b0;
			lanes_reg <= ifra_pkg::LANE_RST;
		end else if (ce_i) begin
			if (cmd_wr && !pend_reg) begin // R04
				dir_reg <= cmd_merged[ifra_pkg::DIR_BIT]; // R05
				up_reg <= cmd_merged[ifra_pkg::UP_BIT];
				down_reg <= cmd_merged[ifra_pkg::DOWN_BIT];
				lanes_reg <= cmd_merged[ifra_pkg::LANE_HI:ifra_pkg::LANE_LO]; // R13
			end
		end
	end

	// Index: software write, read-side pre-step, write-side post-step
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			index_reg <= ifra_pkg::IDX_RST;
		end else if (ce_i) begin
			if (cmd_wr && !pend_reg) begin
				index_reg <= cmd_merged[ifra_pkg::IDX_HI:ifra_pkg::IDX_LO]; // R15
			end else if (data_rd && !pend_reg && step_up) begin
				index_reg <= index_reg + ifra_pkg::IDX_STEP; // R07
			end else if (data_rd && !pend_reg && step_down) begin
				index_reg <= index_reg - ifra_pkg::IDX_STEP; // R09
			end else if (seq_done && pend_reg && op_dir_reg == ifra_pkg::DIR_WRITE) begin
				// Step only once the fabric write has finished
				if (op_up_reg) begin
					index_reg <= index_reg + ifra_pkg::IDX_STEP; // R06
				end else if (op_down_reg) begin
					index_reg <= index_reg - ifra_pkg::IDX_STEP; // R08
				end
			end
		end
	end

	// Software data word, byte-select merged
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wdata_reg <= ifra_pkg::DATA_RST; // R17
		end else if (ce_i) begin
			if (data_wr && !pend_reg) begin // R04
				wdata_reg <= data_merged; // R17
			end
		end
	end

	// Fetched word lands at the same edge that pending clears
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_reg <= ifra_pkg::DATA_RST;
		end else if (ce_i) begin
			if (seq_done && pend_reg && op_dir_reg == ifra_pkg::DIR_READ) begin
				rdata_reg <= seq_rdata; // R03
			end
		end
	end

	// Pending flag; set and clear never coincide because set needs idle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pend_reg <= 1'b0;
		end else if (ce_i) begin
			if (launch_cmd || launch_data) begin
				pend_reg <= 1'b1; // R01 R06 R07 R08 R09
			end else if (seq_done) begin
				pend_reg <= 1'b0; // R02
			end
		end
	end

	// Launch pulse and snapshot of the access kind
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			start_reg <= 1'b0;
			op_dir_reg <= ifra_pkg::DIR_WRITE;
			op_up_reg <= 1'b0;
			op_down_reg <= 1'b0;
		end else if (ce_i) begin
			start_reg <= 1'b0;
			if (launch_cmd) begin
				start_reg <= 1'b1; // R19
				op_dir_reg <= cmd_merged[ifra_pkg::DIR_BIT]; // R05
				op_up_reg <= cmd_merged[ifra_pkg::UP_BIT]; // R11
				op_down_reg <= cmd_merged[ifra_pkg::DOWN_BIT] && !cmd_merged[ifra_pkg::UP_BIT];
			end else if (launch_data) begin
				start_reg <= 1'b1; // R19
				op_dir_reg <= dir_reg;
				op_up_reg <= step_up;
				op_down_reg <= step_down;
			end
		end
	end

	// Fabric sequencer; reads index and data one cycle after the launch
	ifra_fab_seq u_seq (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.start_i(start_reg),
		.dir_i(op_dir_reg),
		.index_i(index_reg),
		.lanes_i(lanes_reg),
		.wdata_i(wdata_reg),
		.done_o(seq_done),
		.rdata_o(seq_rdata),
		.fab_req_o(fab_req_o),
		.fab_we_o(fab_we_o),
		.fab_index_o(fab_index_o),
		.fab_lanes_o(fab_lanes_o),
		.fab_wdata_o(fab_wdata_o),
		.fab_ack_i(fab_ack_i),
		.fab_rdata_i(fab_rdata_i)
	);

	// Writing the pending bit while idle launches
	a_pend_launch: assert property (@(posedge clk_i) disable iff (rst_i) // R01
		ce_i && launch_cmd |=> pend_reg && start_reg)
		else $error("pending write did not launch an access");

	// Pending stays until the sequencer reports done
	a_pend_holds: assert property (@(posedge clk_i) disable iff (rst_i) // R02
		pend_reg && !seq_done |=> pend_reg)
		else $error("pending dropped before access completed");

	// Done clears pending
	a_pend_clears: assert property (@(posedge clk_i) disable iff (rst_i) // R02
		ce_i && seq_done && pend_reg |=> !pend_reg)
		else $error("pending not cleared after completion");

	// Fetched value is in place when pending falls
	a_read_loaded: assert property (@(posedge clk_i) disable iff (rst_i) // R03
		ce_i && seq_done && pend_reg && op_dir_reg |=> rdata_reg == $past(seq_rdata))
		else $error("fabric read value not loaded");

	// Step-up read bumps index and relaunches
	a_step_up_rd: assert property (@(posedge clk_i) disable iff (rst_i) // R07
		ce_i && data_rd && !pend_reg && up_reg |=> index_reg == $past(index_reg) + 16'h0001
		&& pend_reg)
		else $error("step-up read did not advance index");

	// Step-down read only when step-up is clear
	a_step_dn_rd: assert property (@(posedge clk_i) disable iff (rst_i) // R09
		ce_i && data_rd && !pend_reg && down_reg && !up_reg
		|=> index_reg == $past(index_reg) - 16'h0001 && pend_reg)
		else $error("step-down read did not retreat index");

	// Write completion with step-up advances the index
	a_step_up_wr: assert property (@(posedge clk_i) disable iff (rst_i) // R06
		ce_i && seq_done && pend_reg && !op_dir_reg && op_up_reg
		|=> index_reg == $past(index_reg) + 16'h0001)
		else $error("step-up write did not advance index");

	// Launches only from idle
	a_single_access: assert property (@(posedge clk_i) disable iff (rst_i) // R19
		$rose(start_reg) |-> !$past(pend_reg))
		else $error("access launched while another was pending");

	// Reserved bits read zero
	a_rsvd_zero: assert property (@(posedge clk_i) disable iff (rst_i) // R18
		ce_i && take && !wb_we_i && hit_cmd |=> wb_dat_o[27:20] == 8'h00 && wb_ack_o)
		else $error("reserved command bits not zero");

	// Data read view follows direction
	a_data_view: assert property (@(posedge clk_i) disable iff (rst_i) // R16
		ce_i && data_rd |=> wb_dat_o == ($past(dir_reg) ? $past(rdata_reg) : $past(wdata_reg)))
		else $error("data read returned the wrong copy");

endmodule

// ### bench/ifra_fab_model.sv
`timescale 1ns/1ns
module ifra_fab_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Fabric register port, engine side
	input wire logic fab_req_i,
	input wire logic fab_we_i,
	input wire logic [15:0] fab_index_i,
	input wire logic [3:0] fab_lanes_i,
	input wire logic [31:0] fab_wdata_i,
	// Answer back to the engine
	output logic fab_ack_o,
	output logic [31:0] fab_rdata_o
);
	// Sparse register space, unwritten places read zero
	logic [31:0] regs [logic [15:0]];
	// Word being read or merged
	logic [31:0] cur;

	// Stalls at random so both prompt and slow answers occur
	// Read data inverts every cycle outside reset and a read ack, so the last word returns every other cycle
	always @(posedge clk_i) begin
		fab_ack_o <= 1'b0;
		fab_rdata_o <= ~fab_rdata_o;
		if (rst_i) begin
			fab_rdata_o <= 32'h5aa5_0ff0;
		end else if (fab_req_i && !fab_ack_o && $urandom_range(0, 2) == 0) begin
			cur = regs.exists(fab_index_i) ? regs[fab_index_i] : 32'h0000_0000;
			fab_ack_o <= 1'b1;
			if (fab_we_i) begin
				// Only enabled lanes change
				for (int b = 0; b < 4; b++) begin
					if (fab_lanes_i[b]) cur[8*b +: 8] = fab_wdata_i[8*b +: 8];
				end
				regs[fab_index_i] = cur;
			end else begin
				fab_rdata_o <= cur;
			end
		end
	end
endmodule

// ### bench/indirect_fabric_reg_access_tb_top.sv
`timescale 1ns/1ns
module indirect_fabric_reg_access_tb_top;
	// Clock, reset, bus
	logic clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [11:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	// Fabric port between engine and model
	logic fab_req_o, fab_we_o, fab_ack_i;
	logic [15:0] fab_index_o;
	logic [3:0] fab_lanes_o;
	logic [31:0] fab_wdata_o, fab_rdata_i;
	// Score keeping
	int mismatches, checks, cycles;
	// Expected fabric contents
	logic [31:0] shadow [logic [15:0]];
	// Scratch
	logic [31:0] rd, wd, sw;
	logic [15:0] idx, s;
	logic [3:0] ln, top, sl;
	int step;

	ifra_cmd_engine i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.fab_req_o(fab_req_o), .fab_we_o(fab_we_o), .fab_index_o(fab_index_o),
		.fab_lanes_o(fab_lanes_o), .fab_wdata_o(fab_wdata_o), .fab_ack_i(fab_ack_i),
		.fab_rdata_i(fab_rdata_i));

	ifra_fab_model i_fab (.clk_i(clk_i), .rst_i(rst_i), .fab_req_i(fab_req_o),
		.fab_we_i(fab_we_o), .fab_index_i(fab_index_o), .fab_lanes_i(fab_lanes_o),
		.fab_wdata_i(fab_wdata_o), .fab_ack_o(fab_ack_i), .fab_rdata_o(fab_rdata_i));

	// 20 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	// Hang guard, far above the several hundred cycles the run needs
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			end_of_test();
		end
	end

	// Fabric word after a lane-masked write
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] l);
		for (int b = 0; b < 4; b++) begin
			if (l[b]) o[8*b +: 8] = n[8*b +: 8];
		end
		return o;
	endfunction

	// Expected fabric value, zero where never written
	function automatic logic [31:0] fab_val(input logic [15:0] i);
		return shadow.exists(i) ? shadow[i] : 32'h0000_0000;
	endfunction

	// Command word from {pending, direction, up, down}, lanes, index
	function automatic logic [31:0] cmd(input logic [3:0] t, input logic [3:0] l,
		input logic [15:0] i);
		return {t, 8'h00, l, i};
	endfunction

	// Verdict and end of run
	task automatic end_of_test();
		if (mismatches == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// One comparison
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t got %h want %h", $time, got, exp);
		end
	endtask

	// Classic Wishbone cycle, entered just after a rising edge
	task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		// Waits as long as it takes; only the hang guard ends a lost cycle
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		// Registered ack gives one wait state while enabled
		chk(32'(n), 32'h0000_0002);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask

	// Poll the command word until pending clears or 30 polls pass; rd keeps the last word
	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			wb(1'b0, ifra_pkg::CMD_OFS, 32'h0000_0000);
			n++;
		end while (rd[ifra_pkg::PEND_BIT] !== 1'b0 && n < 30);
		chk({31'h0, rd[ifra_pkg::PEND_BIT]}, 32'h0000_0000);
	endtask

	initial begin
		{rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i} = 5'b11000;
		wb_adr_i = 12'h000;
		wb_sel_i = 4'hf;
		wb_dat_i = 32'h0000_0000;
		void'($urandom(32'h0bbe8670));
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		// Reset values and an unmapped hole
		wb(1'b0, ifra_pkg::CMD_OFS, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		wb(1'b0, ifra_pkg::DATA_OFS, 32'h0000_0000);
		chk(rd, ifra_pkg::DATA_RST);
		wb(1'b1, 12'h1b4, 32'hffff_ffff);
		wb(1'b0, 12'h1b4, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		wb(1'b0, ifra_pkg::CMD_OFS, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		// Clock enable low mid-access: the fabric request freezes, then finishes
		wb(1'b1, ifra_pkg::CMD_OFS, cmd(4'hc, 4'hf, 16'h0010));
		ce_i <= 1'b0;
		@(posedge clk_i);
		chk({15'h0, fab_req_o, fab_index_o}, 32'h0001_0010);
		repeat (6) @(posedge clk_i);
		chk({15'h0, fab_req_o, fab_index_o}, 32'h0001_0010);
		ce_i <= 1'b1;
		@(posedge clk_i);
		wait_idle();
		wb(1'b0, ifra_pkg::DATA_OFS, 32'h0000_0000);
		chk(rd, fab_val(16'h0010));
		// Software word as the byte selects merge it
		sw = ifra_pkg::DATA_RST;
		// Single writes with random lanes on a few shared places, then read back
		repeat (10) begin
			idx = 16'h0010 + 16'($urandom_range(0, 3));
			ln = 4'($urandom);
			sl = 4'($urandom);
			wd = $urandom;
			sw = merge(sw, wd, sl);
			wb_sel_i <= sl;
			wb(1'b1, ifra_pkg::DATA_OFS, wd);
			wb_sel_i <= 4'hf;
			wb(1'b1, ifra_pkg::CMD_OFS, cmd(4'h8, ln, idx) | 32'h0ff0_0000);
			wait_idle();
			shadow[idx] = merge(fab_val(idx), sw, ln);
			chk(rd, cmd(4'h0, ln, idx));
			wb(1'b0, ifra_pkg::DATA_OFS, 32'h0000_0000);
			chk(rd, sw);
			wb(1'b1, ifra_pkg::CMD_OFS, cmd(4'hc, ln, idx));
			wait_idle();
			wb(1'b0, ifra_pkg::DATA_OFS, 32'h0000_0000);
			chk(rd, fab_val(idx));
		end
		// Stepped bursts: up, down, then both bits set
		for (int m = 0; m < 3; m++) begin
			top = (m == 0) ? 4'h2 : (m == 1) ? 4'h1 : 4'h3;
			step = (m == 1) ? -1 : 1;
			s = 16'h0100 + 16'($urandom_range(0, 3583));
			idx = s;
			wb(1'b1, ifra_pkg::CMD_OFS, cmd(top, 4'hf, idx));
			for (int k = 0; k < 3; k++) begin
				wd = $urandom;
				wb(1'b1, ifra_pkg::DATA_OFS, wd);
				wait_idle();
				shadow[idx] = wd;
				idx = idx + 16'(step);
				chk(rd, cmd(top, 4'hf, idx));
			end
			idx = s;
			wb(1'b1, ifra_pkg::CMD_OFS, cmd(top | 4'hc, 4'hf, idx));
			for (int k = 0; k < 3; k++) begin
				wait_idle();
				chk(rd, cmd(top | 4'h4, 4'hf, idx));
				// Step bits cleared before the last read
				if (k == 2) wb(1'b1, ifra_pkg::CMD_OFS, cmd(4'h4, 4'hf, idx));
				wb(1'b0, ifra_pkg::DATA_OFS, 32'h0000_0000);
				chk(rd, fab_val(idx));
				if (k < 2) idx = idx + 16'(step);
			end
			wait_idle();
			chk(rd, cmd(4'h4, 4'hf, idx));
		end
		end_of_test();
	end
endmodule
